// File: common/dsc_pkg.sv
// Purpose: shared constants for the dual conversion sequencer
// Assumes: 100 MHz clock, analog levels given as 18-bit counts of one code step
// Notes: register map is word aligned on a 32-bit classic Wishbone slave
`default_nettype none
package dsc_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int RES_BITS = 16;
  localparam int CONV_CH_NS = 800;
  localparam int NORM_PERIOD_NS = 2000;
  localparam int IMP_PERIOD_NS = 2253;
  localparam int CONV_CH_CYC = (CONV_CH_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC = CONV_CH_CYC / RES_BITS;
  localparam int NORM_PERIOD_CYC = (NORM_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int IMP_PERIOD_CYC = (IMP_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEQ_OVERHEAD_CYC = 4;
  localparam logic [7:0] ACQ_NORM_CYC =
    8'(NORM_PERIOD_CYC - 2 * CONV_CH_CYC - SEQ_OVERHEAD_CYC);
  localparam logic [7:0] ACQ_IMP_CYC =
    8'(IMP_PERIOD_CYC - 2 * CONV_CH_CYC - SEQ_OVERHEAD_CYC);
  localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);
  // ****************************************
  // output coding
  // ****************************************
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] MSB_TRIAL = 16'h8000;
  localparam logic [15:0] LSB_MASK = 16'h0001;
  localparam logic signed [18:0] DIFF_MAX = 19'sh0FFFF;
  localparam logic signed [18:0] DIFF_MID = 19'sh08000;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_RESULT_A = 8'h10;
  localparam logic [7:0] REG_RESULT_B = 8'h14;
  localparam int CTRL_IMPULSE = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_PDOWN = 1;
  localparam int ST_PAIR_NOW = 2;
  localparam int ST_PAIR_LAST = 3;
  localparam int EV_CHAN_A = 0;
  localparam int EV_PAIR = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_NONE = 3'h0;
  localparam logic [2:0] PIN_RST = 3'h1;
  localparam int PIN_START = 0;
  localparam int PIN_PAIR = 1;
  localparam int PIN_PD = 2;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_CONV_A = 5'h02,
    S_CONV_B = 5'h04,
    S_ACQ = 5'h08,
    S_PDOWN = 5'h10
  } dsc_state_t;
endpackage
`default_nettype wire

// File: core/dsc_sar_channel.sv
// Purpose: one track-and-hold successive-approximation channel
// Assumes: sample_i is a clamped straight-binary code valid at start_i
// Notes: one trial bit every STEP_CYC cycles, MSB first
`default_nettype none
module dsc_sar_channel
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [15:0] sample_i,
  output logic done_o,
  output logic [15:0] result_o
);
  logic [15:0] hold_ff;
  logic [15:0] trial_ff;
  logic [15:0] mask_ff;
  logic [3:0] step_ff;
  logic run_ff;
  logic [15:0] decided;

  // a trial bit stays only if the trial does not exceed the held level
  assign decided = (trial_ff <= hold_ff) ? trial_ff : (trial_ff & ~mask_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_ff <= CODE_ZERO;
      trial_ff <= CODE_ZERO;
      mask_ff <= CODE_ZERO;
      step_ff <= '0;
      run_ff <= 1'b0;
      done_o <= 1'b0;
      result_o <= CODE_ZERO;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        hold_ff <= sample_i;
        trial_ff <= MSB_TRIAL;
        mask_ff <= MSB_TRIAL;
        step_ff <= '0;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (step_ff != STEP_LAST) begin
          step_ff <= step_ff + 4'h1;
        end else begin
          step_ff <= '0;
          mask_ff <= mask_ff >> 1;
          trial_ff <= decided | (mask_ff >> 1);
          if (mask_ff == LSB_MASK) begin
            run_ff <= 1'b0;
            done_o <= 1'b1;
            result_o <= decided;
          end
        end
      end
    end
  end

  a_sar_exact: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |-> result_o == hold_ff)
    else $error("conversion result differs from held sample");
endmodule
`default_nettype wire

// File: core/dsc_sequencer.sv
// Purpose: pair select, sample, convert A then B, code and latch results
// Assumes: analog levels and ground senses are 18-bit step counts on clk_i
// Notes: control pins pass a three-stage filter; registers on classic Wishbone
`default_nettype none
// Functional notes
// - Both channels of a pair are held at the same instant by two SAR cores, no latency.
// - Normal mode keeps one conversion period of 500 kSPS and keeps the front end powered.
// - Impulse mode powers the front end only while converting, period of 444 kSPS.
// - A high power-down input parks the sequencer in a powered-off state.
// - Each result is a 16-bit straight binary code, zero input gives zero.
// - One step is 2*Vref/65536, an input equal to Vref gives 0x8000.
// - An input above the full span gives 0xFFFF and never wraps.
// - A positive input below its ground sense gives 0x0000 and never wraps.
// - Pair select low converts pair one, high converts pair two.
// - Channel A is always converted before channel B.
// - A falling edge of the start input holds the sample and starts converting.
// - In impulse mode a start held low at the end of acquisition starts at once.
// - Busy rises at conversion start and falls when both results are latched.
// - End-of-channel pulses low once for each channel conversion.
module dsc_sequencer
  import dsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic conversion_start_n_i,
  input wire logic pair_select_i,
  input wire logic power_down_input_i,
  input wire logic [17:0] chan_a_input_1_i,
  input wire logic [17:0] chan_a_input_2_i,
  input wire logic [17:0] chan_b_input_1_i,
  input wire logic [17:0] chan_b_input_2_i,
  input wire logic [17:0] ground_sense_input_a_i,
  input wire logic [17:0] ground_sense_input_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy_o,
  output logic end_of_chan_n_o,
  output logic analog_on_o,
  output logic [15:0] result_a_o,
  output logic [15:0] result_b_o,
  output logic irq_o
);
  // ****************************************
  // pin filters
  // ****************************************
  logic [2:0] pin_raw;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] pin_ff;
  logic start_prev_ff;
  logic start_fall;
  logic pd_lvl;
  logic pair_lvl;

  assign pin_raw = {power_down_input_i, pair_select_i, conversion_start_n_i};

  // a level counts only once stages two and three agree
  for (genvar g = 0; g < 3; g++) begin : g_pin
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync1_ff[g] <= PIN_RST[g];
        sync2_ff[g] <= PIN_RST[g];
        sync3_ff[g] <= PIN_RST[g];
        pin_ff[g] <= PIN_RST[g];
      end else begin
        sync1_ff[g] <= pin_raw[g];
        sync2_ff[g] <= sync1_ff[g];
        sync3_ff[g] <= sync2_ff[g];
        if (sync2_ff[g] == sync3_ff[g]) begin
          pin_ff[g] <= sync3_ff[g];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_prev_ff <= PIN_RST[PIN_START];
    end else begin
      start_prev_ff <= pin_ff[PIN_START];
    end
  end

  assign start_fall = start_prev_ff & ~pin_ff[PIN_START];
  assign pd_lvl = pin_ff[PIN_PD];
  assign pair_lvl = pin_ff[PIN_PAIR];

  // ****************************************
  // input coding
  // ****************************************
  function automatic logic [15:0] clamp_code(input logic signed [18:0] diff);
    if (diff < 0) begin
      clamp_code = CODE_ZERO;
    end else if (diff > DIFF_MAX) begin
      clamp_code = CODE_FULL;
    end else begin
      clamp_code = diff[15:0];
    end
  endfunction

  logic [17:0] sel_a;
  logic [17:0] sel_b;
  logic signed [18:0] diff_a;
  logic signed [18:0] diff_b;
  logic [15:0] code_a;
  logic [15:0] code_b;

  // analog levels are modelled as already settled values on this clock
  assign sel_a = pair_lvl ? chan_a_input_2_i : chan_a_input_1_i;
  assign sel_b = pair_lvl ? chan_b_input_2_i : chan_b_input_1_i;
  assign diff_a = signed'({1'b0, sel_a}) - signed'({1'b0, ground_sense_input_a_i});
  assign diff_b = signed'({1'b0, sel_b}) - signed'({1'b0, ground_sense_input_b_i});
  assign code_a = clamp_code(diff_a);
  assign code_b = clamp_code(diff_b);

  // ****************************************
  // sequencer
  // ****************************************
  dsc_state_t st_ff;
  logic [7:0] acq_cnt_ff;
  logic [7:0] acq_last;
  logic acq_end;
  logic impulse_ff;
  logic go;
  logic auto_go;
  logic refused;
  logic [15:0] hold_b_ff;
  logic pair_cap_ff;
  logic pair_last_ff;
  logic a_done;
  logic b_done;
  logic [15:0] a_res;
  logic [15:0] b_res;
  logic [15:0] a_tmp_ff;

  // impulse mode trades throughput for a longer powered-off acquisition
  assign acq_last = (impulse_ff ? ACQ_IMP_CYC : ACQ_NORM_CYC) - 8'h01;
  assign acq_end = (st_ff == S_ACQ) && (acq_cnt_ff == acq_last);
  assign auto_go = acq_end && impulse_ff && !pd_lvl && !pin_ff[PIN_START];
  assign go = ((st_ff == S_IDLE) && !pd_lvl && start_fall) || auto_go;
  // edges while converting, acquiring or powered down are dropped
  assign refused = start_fall && !go;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= S_ACQ;
      acq_cnt_ff <= '0;
    end else begin
      case (st_ff)
        S_IDLE: begin
          if (pd_lvl) begin
            st_ff <= S_PDOWN;
          end else if (go) begin
            st_ff <= S_CONV_A;
          end
        end
        S_CONV_A: begin
          if (a_done) begin
            st_ff <= S_CONV_B;
          end
        end
        S_CONV_B: begin
          if (b_done) begin
            st_ff <= S_ACQ;
            acq_cnt_ff <= '0;
          end
        end
        S_ACQ: begin
          acq_cnt_ff <= acq_cnt_ff + 8'h01;
          if (acq_end) begin
            if (pd_lvl) begin
              st_ff <= S_PDOWN;
            end else if (auto_go) begin
              st_ff <= S_CONV_A;
            end else begin
              st_ff <= S_IDLE;
            end
          end
        end
        S_PDOWN: begin
          if (!pd_lvl) begin
            st_ff <= S_ACQ;
            acq_cnt_ff <= '0;
          end
        end
        default: begin
          st_ff <= S_ACQ;
          acq_cnt_ff <= '0;
        end
      endcase
    end
  end

  // channel B level is frozen together with channel A
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_b_ff <= CODE_ZERO;
      pair_cap_ff <= 1'b0;
    end else if (go) begin
      hold_b_ff <= code_b;
      pair_cap_ff <= pair_lvl;
    end
  end

  dsc_sar_channel u_sar_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(go),
    .sample_i(code_a),
    .done_o(a_done),
    .result_o(a_res)
  );

  dsc_sar_channel u_sar_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(a_done),
    .sample_i(hold_b_ff),
    .done_o(b_done),
    .result_o(b_res)
  );

  // ****************************************
  // handshake pins and results
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      end_of_chan_n_o <= 1'b1;
    end else begin
      if (go) begin
        busy_o <= 1'b1;
      end else if (b_done) begin
        busy_o <= 1'b0;
      end
      end_of_chan_n_o <= ~(a_done | b_done);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_tmp_ff <= CODE_ZERO;
      result_a_o <= CODE_ZERO;
      result_b_o <= CODE_ZERO;
      pair_last_ff <= 1'b0;
    end else begin
      if (a_done) begin
        a_tmp_ff <= a_res;
      end
      if (b_done) begin
        result_a_o <= a_tmp_ff;
        result_b_o <= b_res;
        pair_last_ff <= pair_cap_ff;
      end
    end
  end

  // normal mode keeps the front end up, so power does not track the rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_on_o <= 1'b0;
    end else begin
      analog_on_o <= (st_ff != S_PDOWN) &&
        (!impulse_ff || st_ff == S_CONV_A || st_ff == S_CONV_B);
    end
  end

  // ****************************************
  // bus slave and interrupts
  // ****************************************
  logic acc;
  logic wr;
  logic [EV_W-1:0] irq_stat_ff;
  logic [EV_W-1:0] irq_mask_ff;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic [31:0] rd_val;

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign ev = {refused, b_done, a_done};
  assign clr = (wr && wb_adr_i == REG_IRQ_STAT) ? wb_dat_i[EV_W-1:0] : EV_NONE;

  always_comb begin
    rd_val = '0;
    case (wb_adr_i)
      REG_CTRL: rd_val[CTRL_IMPULSE] = impulse_ff;
      REG_STATUS: begin
        rd_val[ST_BUSY] = busy_o;
        rd_val[ST_PDOWN] = (st_ff == S_PDOWN);
        rd_val[ST_PAIR_NOW] = pair_lvl;
        rd_val[ST_PAIR_LAST] = pair_last_ff;
      end
      REG_IRQ_STAT: rd_val[EV_W-1:0] = irq_stat_ff;
      REG_IRQ_MASK: rd_val[EV_W-1:0] = irq_mask_ff;
      REG_RESULT_A: rd_val[15:0] = result_a_o;
      REG_RESULT_B: rd_val[15:0] = result_b_o;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= rd_val;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      impulse_ff <= 1'b0;
      irq_mask_ff <= EV_NONE;
    end else if (wr) begin
      if (wb_adr_i == REG_CTRL) begin
        impulse_ff <= wb_dat_i[CTRL_IMPULSE];
      end
      if (wb_adr_i == REG_IRQ_MASK) begin
        irq_mask_ff <= wb_dat_i[EV_W-1:0];
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= EV_NONE;
      irq_o <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
    go |=> busy_o && st_ff == S_CONV_A)
    else $error("start did not raise busy");

  a_busy_end: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(busy_o) |-> !end_of_chan_n_o && result_b_o == $past(b_res))
    else $error("busy fell before results latched");

  a_eoc_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    !end_of_chan_n_o |=> end_of_chan_n_o)
    else $error("end of channel pulse too long");

  a_a_first: assert property (@(posedge clk_i) disable iff (rst_i)
    b_done |-> st_ff == S_CONV_B && !a_done)
    else $error("channel b finished outside its turn");

  a_clamp_high: assert property (@(posedge clk_i) disable iff (rst_i)
    diff_a > DIFF_MAX |-> code_a == CODE_FULL)
    else $error("overrange not saturated");

  a_clamp_low: assert property (@(posedge clk_i) disable iff (rst_i)
    diff_b < 0 |-> code_b == CODE_ZERO)
    else $error("underrange not saturated");

  a_mid_code: assert property (@(posedge clk_i) disable iff (rst_i)
    diff_a == DIFF_MID |-> code_a == CODE_MID)
    else $error("midscale code wrong");

  a_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(b_done) |-> $stable(result_a_o) && $stable(result_b_o))
    else $error("results changed without a conversion");

  a_pair_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    go && pair_lvl |=> hold_b_ff == $past(clamp_code(diff_b)) && pair_cap_ff)
    else $error("wrong pair captured");

  a_auto_start: assert property (@(posedge clk_i) disable iff (rst_i)
    acq_end && impulse_ff && !pd_lvl && !pin_ff[PIN_START] |=> busy_o)
    else $error("impulse restart missed");

  a_pd_off: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff == S_PDOWN |=> !analog_on_o)
    else $error("front end on while powered down");
endmodule
`default_nettype wire

// File: bench/dsc_host_model.sv
// Purpose: host side model driving the conversion pins
// Assumes: one clock, trigger pulses come from the bench
// Notes: pair select only moves while the converter is idle
`default_nettype none
module dsc_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic pair_i,
  input wire logic hold_i,
  input wire logic pd_i,
  input wire logic busy_i,
  output logic conversion_start_n_o,
  output logic pair_select_o,
  output logic power_down_input_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_ff;
  // ****************************************
  // start pin sequencing
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 5'h00;
      conversion_start_n_o <= 1'b1;
      pair_select_o <= 1'b0;
      power_down_input_o <= 1'b0;
    end else begin
      power_down_input_o <= pd_i;
      if (go_i && cnt_ff == 5'h00) begin
        cnt_ff <= 5'h01;
        // settles well before the start edge, never mid-conversion
        if (!busy_i) begin
          pair_select_o <= pair_i;
        end
      end else if (cnt_ff != 5'h00) begin
        if (cnt_ff == 5'h04) begin
          conversion_start_n_o <= 1'b0;
        end
        if (cnt_ff < 5'h14) begin
          cnt_ff <= cnt_ff + 5'h01;
        end else if (!hold_i) begin
          conversion_start_n_o <= 1'b1;
          cnt_ff <= 5'h00;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: 100 MHz clock, registers on classic Wishbone
// Notes: analog levels are step counts, so codes follow by subtraction
`default_nettype none
module testbench;
  import dsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0, pair = 1'b0, hold = 1'b0, pd = 1'b0;
  logic start_n, pair_sel, pd_pin;
  logic [17:0] a1 = 18'h0, a2 = 18'h0, b1 = 18'h0, b2 = 18'h0, ga = 18'h0, gb = 18'h0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, busy, eoc_n, an_on, irq;
  logic [15:0] res_a, res_b;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  dsc_host_model dsc_host_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .pair_i(pair), .hold_i(hold), .pd_i(pd), .busy_i(busy),
    .conversion_start_n_o(start_n), .pair_select_o(pair_sel), .power_down_input_o(pd_pin));
  dsc_sequencer dsc_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
    .conversion_start_n_i(start_n), .pair_select_i(pair_sel), .power_down_input_i(pd_pin),
    .chan_a_input_1_i(a1), .chan_a_input_2_i(a2), .chan_b_input_1_i(b1),
    .chan_b_input_2_i(b2), .ground_sense_input_a_i(ga), .ground_sense_input_b_i(gb),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy),
    .end_of_chan_n_o(eoc_n), .analog_on_o(an_on), .result_a_o(res_a),
    .result_b_o(res_b), .irq_o(irq));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude();
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic start(input logic p, input logic h);
    @(posedge clk_i);
    pair <= p;
    hold <= h;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 600) begin
      tick(1);
      n++;
    end
    chk({31'h0, busy}, {31'h0, v});
  endtask
  // counts busy cycles; the channel A pulse lands inside busy, the channel B pulse in the cycle busy falls
  task automatic conv(output int len);
    int eocs;
    eocs = 0;
    len = 0;
    wait_busy(1'b1);
    while (busy === 1'b1 && len < 400) begin
      tick(1);
      len++;
      if (eoc_n === 1'b0) eocs++;
    end
    chk(32'(eocs), 32'h2);
    chk({31'h0, eoc_n}, 32'h0);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk({res_a, res_b}, 32'h0);
    chk({28'h0, busy, eoc_n, irq, an_on}, 32'h5);
    rd(REG_CTRL, 32'h0);
    rd(REG_IRQ_MASK, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
  endtask
  task automatic one_code(input logic p, input logic [17:0] va1, va2, vb1, vb2, vga, vgb,
                          input logic [15:0] ea, eb);
    int len;
    @(posedge clk_i);
    a1 <= va1;
    a2 <= va2;
    b1 <= vb1;
    b2 <= vb2;
    ga <= vga;
    gb <= vgb;
    start(p, 1'b0);
    conv(len);
    chk(32'(len <= NORM_PERIOD_CYC - ACQ_NORM_CYC), 32'h1);
    chk({31'h0, an_on}, 32'h1);
    chk({res_a, res_b}, {ea, eb});
    @(posedge clk_i);
    ga <= 18'h00100;
    gb <= 18'h00100;
    tick(60);
    chk({res_a, res_b}, {ea, eb});
  endtask
  task automatic t_codes();
    one_code(1'b0, 18'h08005, 18'h1FFFF, 18'h00002, 18'h1FFFF, 18'h5, 18'h1,
             16'h8000, 16'h0001);
    one_code(1'b1, 18'h00010, 18'h10000, 18'h00010, 18'h00003, 18'h0, 18'h7,
             16'hFFFF, 16'h0000);
    one_code(1'b0, 18'h0FFFF, 18'h0, 18'h08001, 18'h0, 18'h0, 18'h0,
             16'hFFFF, 16'h8001);
  endtask
  task automatic t_irq();
    int len;
    wr(REG_IRQ_MASK, 32'h6);
    wr(REG_IRQ_STAT, 32'h7);
    start(1'b0, 1'b0);
    wait_busy(1'b1);
    tick(30);
    // second edge lands while busy and must be ignored
    start(1'b0, 1'b0);
    conv(len);
    tick(60);
    chk({30'h0, busy, irq}, 32'h1);
    rd(REG_IRQ_STAT, 32'h7);
    wr(REG_IRQ_STAT, 32'h6);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_MASK, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    wr(REG_IRQ_MASK, 32'h0);
  endtask
  task automatic t_pdown();
    @(posedge clk_i);
    pd <= 1'b1;
    tick(20);
    chk({31'h0, an_on}, 32'h0);
    rd(REG_STATUS, 32'h2);
    start(1'b0, 1'b0);
    tick(80);
    chk({31'h0, busy}, 32'h0);
    @(posedge clk_i);
    pd <= 1'b0;
    tick(80);
    chk({31'h0, an_on}, 32'h1);
  endtask
  task automatic t_impulse();
    int len;
    int n;
    n = 0;
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 32'h1);
    tick(70);
    start(1'b1, 1'b1);
    conv(len);
    tick(5);
    chk({31'h0, an_on}, 32'h0);
    while (busy !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk({31'h0, busy}, 32'h1);
    chk(32'(len + 5 + n <= IMP_PERIOD_CYC), 32'h1);
    @(posedge clk_i);
    hold <= 1'b0;
    conv(len);
    tick(80);
    chk({31'h0, busy}, 32'h0);
    wr(REG_CTRL, 32'h0);
  endtask
  // ****************************************
  // main sequence and hang guard
  // ****************************************
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(60);
    t_reset();
    t_codes();
    t_irq();
    t_pdown();
    t_impulse();
    conclude();
  end
endmodule
`default_nettype wire
